//--- adcs_consts.svh
// Constants of the conversion sequencer: offsets, fields, counts
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define ADCS_OFS_CTRL 8'h00
`define ADCS_OFS_STAT 8'h04
`define ADCS_OFS_RES0 8'h10
`define ADCS_OFS_BUF0 8'h20
`define ADCS_RES_MASK 8'hF3
// ****************************************
// Control fields
// ****************************************
`define ADCS_CTL_START 0
`define ADCS_CTL_CKS 1
`define ADCS_CTL_PWR 2
`define ADCS_CTL_BUF 3
`define ADCS_CTL_SIM 4
`define ADCS_CTL_TRG 5
`define ADCS_CTL_CONT 6
`define ADCS_CTL_CH_LO 8
`define ADCS_CTL_CH_HI 9
`define ADCS_CTL_RSVD 7
`define ADCS_CTL_RST 10'h000
// ****************************************
// Status fields
// ****************************************
`define ADCS_ST_BUSY 0
`define ADCS_ST_PWR 1
`define ADCS_ST_WARM 2
`define ADCS_ST_CH_LO 8
// ****************************************
// Timing
// ****************************************
`define ADCS_CLK_MHZ 25
`define ADCS_WARM_CYC 8'hC8
`define ADCS_CONV_FAST 8'h14
`define ADCS_CONV_SLOW 8'h28
`define ADCS_FIRST_CONV_NS 2900
`define ADCS_CONT_CONV_NS 1400
`define ADCS_FIRST_CONV_CYC ((`ADCS_FIRST_CONV_NS * `ADCS_CLK_MHZ + 999) / 1000)
`define ADCS_CONT_CONV_CYC ((`ADCS_CONT_CONV_NS * `ADCS_CLK_MHZ + 999) / 1000)
`endif

//--- adcs_pkg.sv
// Types of the conversion sequencer
package adcs_pkg;
  typedef enum logic [1:0] {
    ADCS_IDLE = 2'h0,
    ADCS_WARM = 2'h1,
    ADCS_SAMP = 2'h3,
    ADCS_CONV = 2'h2
  } adcs_state_e;
  typedef logic [9:0] adcs_data_t;
  typedef logic [1:0] adcs_ch_t;
endpackage

//--- adcs_core_if.sv
// Links between the sequencer core, its cycle timer and its result store
`timescale 1ns/1ps
interface adcs_core_if;
  logic tmr_load;
  logic [7:0] tmr_len;
  logic tmr_done;
  logic res_wr;
  logic res_buf_en;
  adcs_pkg::adcs_ch_t res_ch;
  adcs_pkg::adcs_data_t res_data;
  logic [2:0] rd_idx;
  adcs_pkg::adcs_data_t rd_data;
  modport ctl(output tmr_load, tmr_len, res_wr, res_buf_en, res_ch, res_data, rd_idx,
              input tmr_done, rd_data);
  modport tmr(input tmr_load, tmr_len, output tmr_done);
  modport res(input res_wr, res_buf_en, res_ch, res_data, rd_idx, output rd_data);
endinterface

//--- adcs_timer.sv
// Down counter that times warm-up and conversion periods
`timescale 1ns/1ps
module adcs_timer (
  input wire logic clk,
  input wire logic sys_rst,
  adcs_core_if.tmr bus
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (bus.tmr_load) begin
      cnt_d = bus.tmr_len;
    end else if (cnt_q != 8'h00) begin
      cnt_d = cnt_q - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Done in the last cycle of a period of tmr_len cycles
  assign bus.tmr_done = (cnt_q == 8'h01);
endmodule

//--- adcs_results.sv
// Per-channel result and buffer registers
`timescale 1ns/1ps
module adcs_results (
  input wire logic clk,
  input wire logic sys_rst,
  adcs_core_if.res bus
);
  adcs_pkg::adcs_data_t res_q [4];
  adcs_pkg::adcs_data_t res_d [4];
  adcs_pkg::adcs_data_t buf_q [4];
  adcs_pkg::adcs_data_t buf_d [4];

  always_comb begin
    res_d = res_q;
    buf_d = buf_q;
    if (bus.res_wr) begin
      // Old value moves to the buffer in the same cycle as the new one lands
      if (bus.res_buf_en) begin
        buf_d[bus.res_ch] = res_q[bus.res_ch];
      end
      res_d[bus.res_ch] = bus.res_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        res_q[i] <= 10'h000;
        buf_q[i] <= 10'h000;
      end
    end else begin
      res_q <= res_d;
      buf_q <= buf_d;
    end
  end

  assign bus.rd_data = bus.rd_idx[2] ? buf_q[bus.rd_idx[1:0]] : res_q[bus.rd_idx[1:0]];
endmodule

//--- adcs_top.sv
// Conversion sequencer with APB register access
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`include "adcs_consts.svh"
module adcs_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic multifunction_timer_trigger,
  input wire logic [9:0] adc_data,
  output logic analog_power,
  output logic sample_hold,
  output logic sample_pair,
  output logic [1:0] conv_ch
);
  // ****************************************
  // Declarations
  // ****************************************
  adcs_core_if core ();
  adcs_pkg::adcs_state_e state_q;
  adcs_pkg::adcs_state_e state_d;
  logic [9:0] ctrl_q;
  logic [9:0] ctrl_d;
  logic [9:0] ctrl_new;
  logic power_q;
  logic power_d;
  logic first_q;
  logic first_d;
  logic second_q;
  logic second_d;
  logic hold_q;
  logic hold_d;
  logic pair_q;
  logic pair_d;
  adcs_pkg::adcs_ch_t ch_q;
  adcs_pkg::adcs_ch_t ch_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic acc_wait;
  logic acc_done;
  logic wr_ctrl;
  logic start_set;
  logic finish;

  // ****************************************
  // Helpers
  // ****************************************
  // Length of one conversion
  function automatic logic [7:0] conv_len(input logic first, input logic clock_select_bit);
    logic [7:0] len;
    len = clock_select_bit ? `ADCS_CONV_SLOW : `ADCS_CONV_FAST;
    // First step after a start kept at or above the single-conversion minimum time
    if (first && len < 8'(`ADCS_FIRST_CONV_CYC)) begin
      len = 8'(`ADCS_FIRST_CONV_CYC);
    end
    return len;
  endfunction

  function automatic logic is_result(input logic [7:0] addr);
    return ((addr & `ADCS_RES_MASK) == `ADCS_OFS_RES0)
        || ((addr & `ADCS_RES_MASK) == `ADCS_OFS_BUF0);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == `ADCS_OFS_CTRL || addr == `ADCS_OFS_STAT || is_result(addr);
  endfunction

  // Channel field of a control word
  function automatic adcs_pkg::adcs_ch_t ctl_ch(input logic [9:0] c);
    return c[`ADCS_CTL_CH_HI:`ADCS_CTL_CH_LO];
  endfunction

  // Partner channel of a pair, wrapping from the last to the first
  function automatic adcs_pkg::adcs_ch_t pair_ch(input adcs_pkg::adcs_ch_t ch);
    return ch + 2'h1;
  endfunction

  // Status word as software sees it
  function automatic logic [31:0] stat_word(input adcs_pkg::adcs_state_e st, input logic power_mode_bit,
                                            input adcs_pkg::adcs_ch_t ch);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ADCS_ST_BUSY] = st != adcs_pkg::ADCS_IDLE;
    w[`ADCS_ST_PWR] = power_mode_bit;
    w[`ADCS_ST_WARM] = st == adcs_pkg::ADCS_WARM;
    w[`ADCS_ST_CH_LO +: 2] = ch;
    return w;
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  adcs_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(core.tmr)
  );

  adcs_results u_results (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus(core.res)
  );

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state: data is fetched while pready is low, so reads see stable flops
  assign acc_wait = psel && penable && !pready_q;
  assign acc_done = psel && penable && pready_q;
  assign wr_ctrl = acc_done && pwrite && paddr == `ADCS_OFS_CTRL;
  assign core.rd_idx = {paddr[5], paddr[3:2]};

  always_comb begin
    pready_d = acc_wait;
    pslverr_d = acc_wait && !is_mapped(paddr);
    prdata_d = prdata_q;
    if (acc_wait) begin
      prdata_d = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == `ADCS_OFS_CTRL) begin
          prdata_d[9:0] = ctrl_q;
        end else if (paddr == `ADCS_OFS_STAT) begin
          prdata_d = stat_word(state_q, power_q, ch_q);
        end else if (is_result(paddr)) begin
          prdata_d[9:0] = core.rd_data;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Control as it stands after a write this cycle, so one write sets mode and start
  assign ctrl_new = wr_ctrl ? pwdata[9:0] : ctrl_q;

  // Either source may be picked; the other one is ignored
  assign start_set = ctrl_new[`ADCS_CTL_TRG] ? multifunction_timer_trigger
                   : (wr_ctrl && pwdata[`ADCS_CTL_START]);

  always_comb begin
    state_d = state_q;
    power_d = power_q || ctrl_q[`ADCS_CTL_PWR];
    first_d = first_q;
    second_d = second_q;
    ch_d = ch_q;
    hold_d = 1'b0;
    pair_d = 1'b0;
    finish = 1'b0;
    core.tmr_load = 1'b0;
    core.tmr_len = conv_len(first_q, ctrl_q[`ADCS_CTL_CKS]);
    core.res_wr = 1'b0;
    core.res_buf_en = ctrl_q[`ADCS_CTL_BUF];
    core.res_ch = ch_q;
    core.res_data = adc_data;
    unique case (state_q)
      adcs_pkg::ADCS_IDLE: begin
        // Stale control would start with the old mode and channel
        if (start_set) begin
          first_d = 1'b1;
          second_d = 1'b0;
          ch_d = ctl_ch(ctrl_new);
          power_d = 1'b1;
          if (!ctrl_new[`ADCS_CTL_PWR]) begin
            core.tmr_load = 1'b1;
            core.tmr_len = `ADCS_WARM_CYC;
            state_d = adcs_pkg::ADCS_WARM;
          end else begin
            hold_d = 1'b1;
            pair_d = ctrl_new[`ADCS_CTL_SIM];
            state_d = adcs_pkg::ADCS_SAMP;
          end
        end
      end
      adcs_pkg::ADCS_WARM: begin
        if (core.tmr_done) begin
          hold_d = 1'b1;
          pair_d = ctrl_q[`ADCS_CTL_SIM];
          state_d = adcs_pkg::ADCS_SAMP;
        end
      end
      adcs_pkg::ADCS_SAMP: begin
        core.tmr_load = 1'b1;
        state_d = adcs_pkg::ADCS_CONV;
      end
      adcs_pkg::ADCS_CONV: begin
        if (core.tmr_done) begin
          core.res_wr = 1'b1;
          first_d = 1'b0;
          if (ctrl_q[`ADCS_CTL_SIM] && !second_q) begin
            // Second held input converts without a new sample
            second_d = 1'b1;
            ch_d = pair_ch(ch_q);
            core.tmr_load = 1'b1;
            core.tmr_len = conv_len(1'b0, ctrl_q[`ADCS_CTL_CKS]);
          end else if (ctrl_q[`ADCS_CTL_CONT] && ctrl_q[`ADCS_CTL_START]) begin
            // Next round goes straight to sampling, no warm-up
            second_d = 1'b0;
            ch_d = ctl_ch(ctrl_q);
            hold_d = 1'b1;
            pair_d = ctrl_q[`ADCS_CTL_SIM];
            state_d = adcs_pkg::ADCS_SAMP;
          end else begin
            finish = 1'b1;
            power_d = ctrl_q[`ADCS_CTL_PWR];
            state_d = adcs_pkg::ADCS_IDLE;
          end
        end
      end
      default: begin
        state_d = adcs_pkg::ADCS_IDLE;
      end
    endcase
  end

  // Control bits; a new start beats the end-of-conversion clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = pwdata[9:0];
      // Reserved bit always reads 0
      ctrl_d[`ADCS_CTL_RSVD] = 1'b0;
      ctrl_d[`ADCS_CTL_START] = ctrl_q[`ADCS_CTL_START] && pwdata[`ADCS_CTL_START];
    end
    if (finish) begin
      ctrl_d[`ADCS_CTL_START] = 1'b0;
    end
    if (start_set) begin
      ctrl_d[`ADCS_CTL_START] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= adcs_pkg::ADCS_IDLE;
      ctrl_q <= `ADCS_CTL_RST;
      power_q <= 1'b0;
      first_q <= 1'b0;
      second_q <= 1'b0;
      hold_q <= 1'b0;
      pair_q <= 1'b0;
      ch_q <= 2'h0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      power_q <= power_d;
      first_q <= first_d;
      second_q <= second_d;
      hold_q <= hold_d;
      pair_q <= pair_d;
      ch_q <= ch_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign analog_power = power_q;
  assign sample_hold = hold_q;
  assign sample_pair = pair_q;
  assign conv_ch = ch_q;
endmodule

//--- adcs_analog_model.sv
// Model of the analog section seen by the sequencer
`timescale 1ns/1ps
module adcs_analog_model (
  input wire logic analog_power,
  input wire logic [1:0] conv_ch,
  input wire logic [9:0] level,
  output logic [9:0] adc_data
);
  // Unpowered input shows inverted data, so a stale sample never matches
  assign adc_data = analog_power ? (level ^ {8'h00, conv_ch}) : ~level;
endmodule

//--- adcs_top_props.sv
// Port checks of the conversion sequencer
`timescale 1ns/1ps
module adcs_top_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic analog_power,
  input wire logic sample_hold,
  input wire logic sample_pair,
  input wire logic [1:0] conv_ch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_quiet: assert property (
    $fell(sys_rst) |-> !analog_power && !sample_hold && conv_ch == 2'h0) else $error("not idle");
  a_pair_with_hold: assert property (
    sample_pair |-> sample_hold) else $error("pair without sample");
  a_hold_powered: assert property (
    sample_hold |-> analog_power) else $error("sample while unpowered");
  a_conv_gap: assert property (
    sample_hold |=> !sample_hold [*8]) else $error("samples too close");
  a_warm_gap: assert property (
    $rose(analog_power) && !sample_hold |-> !sample_hold [*8]) else $error("no warm-up");
  a_ready_wait: assert property (
    psel && penable && !$past(penable) |-> !pready ##1 pready) else $error("wait state wrong");
  a_ready_pulse: assert property (
    pready |=> !pready) else $error("ready too long");
  a_err_ready: assert property (
    pslverr |-> pready && psel) else $error("error without ready");
  a_err_zero: assert property (
    pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
endmodule
bind adcs_top adcs_top_props u_props (.clk, .sys_rst, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .analog_power, .sample_hold, .sample_pair, .conv_ch);

//--- tb_adcs_top.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`include "adcs_consts.svh"
module tb_adcs_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic trig = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, analog_power, sample_hold, sample_pair;
  logic [1:0] conv_ch;
  logic [9:0] adc_data;
  logic [9:0] level = 10'h000;
  logic [9:0] old;
  integer errors = 0, samples_checked = 0, seed = 23796, cyc = 0, e_cyc = 0, i;
  logic [32:0] rd_q[$];
  logic [8:0] tm_q[$];
  always #20 clk = ~clk;
  adcs_top uut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .multifunction_timer_trigger(trig), .adc_data, .analog_power, .sample_hold,
    .sample_pair, .conv_ch);
  adcs_analog_model u_model (.analog_power, .conv_ch, .level, .adc_data);
  // ****************************************
  // Compare and report
  // ****************************************
  task automatic chk_rd(input logic [32:0] e, input logic [32:0] a);
    samples_checked++;
    if (a !== e) begin
      errors++;
      $display("ERROR %0t read %h expected %h", $time, a, e);
    end
  endtask
  task automatic chk_gap(input logic [8:0] e, input logic [8:0] a);
    samples_checked++;
    if (a !== e) begin
      errors++;
      $display("ERROR %0t sample gap %h expected %h", $time, a, e);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Monitor: stamps each start, then pairs each sample with the oldest note
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      errors++;
      final_report;
    end
    if (!sys_rst) begin
      if (psel && penable && pready && !pwrite)
        chk_rd(rd_q.size() > 0 ? rd_q.pop_front() : 'x, {pslverr, prdata});
      if (sample_hold) begin
        chk_gap(tm_q.size() > 0 ? tm_q.pop_front() : 'x, {sample_pair, 8'(cyc - e_cyc)});
        e_cyc = cyc;
      end
      if ((psel && penable && pready && pwrite && paddr == `ADCS_OFS_CTRL && pwdata[0]) || trig)
        e_cyc = cyc;
    end
  end
  // ****************************************
  // Drivers
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic note(input logic [8:0] g);
    tm_q.push_back(g);
  endtask
  task automatic drain;
    while (tm_q.size() > 0) @(posedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`ADCS_OFS_CTRL, 33'h0);
    xfer(1'b1, `ADCS_OFS_STAT, 32'hFFFF_FFFF);
    rd(`ADCS_OFS_STAT, 33'h0);
    rd(8'h40, {1'b1, 32'h0});
    done("reset");
    level <= 10'($random(seed));
    note(9'h0C9);
    xfer(1'b1, `ADCS_OFS_CTRL, 32'h101);
    rd(`ADCS_OFS_STAT, 33'h107);
    drain;
    repeat (80) @(posedge clk);
    rd(`ADCS_OFS_STAT, 33'h100);
    rd(`ADCS_OFS_RES0 + 8'h04, {23'h0, level ^ 10'h001});
    done("low power");
    xfer(1'b1, `ADCS_OFS_CTRL, 32'h101);
    repeat (50) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`ADCS_OFS_STAT, 33'h0);
    rd(`ADCS_OFS_CTRL, 33'h0);
    repeat (250) @(posedge clk);
    done("reset in warm-up");
    note(9'h001);
    xfer(1'b1, `ADCS_OFS_CTRL, 32'h205);
    repeat (80) @(posedge clk);
    rd(`ADCS_OFS_CTRL, 33'h204);
    rd(`ADCS_OFS_RES0 + 8'h08, {23'h0, level ^ 10'h002});
    old = level;
    level <= 10'($random(seed));
    note(9'h001);
    xfer(1'b1, `ADCS_OFS_CTRL, 32'h20D);
    repeat (80) @(posedge clk);
    rd(`ADCS_OFS_RES0 + 8'h08, {23'h0, level ^ 10'h002});
    rd(`ADCS_OFS_BUF0 + 8'h08, {23'h0, old ^ 10'h002});
    done("single and buffer");
    level <= 10'($random(seed));
    xfer(1'b1, `ADCS_OFS_CTRL, 32'h024);
    note(9'h001);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    drain;
    repeat (80) @(posedge clk);
    rd(`ADCS_OFS_RES0, {23'h0, level});
    done("timer trigger");
    for (i = 0; i < 2; i++) begin
      note(9'h001);
      note(9'h04A);
      note(i ? 9'h029 : 9'h015);
      note(i ? 9'h029 : 9'h015);
      xfer(1'b1, `ADCS_OFS_CTRL, 32'h45 | (i << 1));
      drain;
      xfer(1'b1, `ADCS_OFS_CTRL, 32'h04 | (i << 1));
      repeat (60) @(posedge clk);
      rd(`ADCS_OFS_CTRL, 33'h04 | (i << 1));
    end
    done("continuous");
    level <= 10'($random(seed));
    note(9'h101);
    xfer(1'b1, `ADCS_OFS_CTRL, 32'h315);
    repeat (110) @(posedge clk);
    rd(`ADCS_OFS_RES0 + 8'h0C, {23'h0, level ^ 10'h003});
    rd(`ADCS_OFS_RES0, {23'h0, level});
    done("simultaneous");
    final_report;
  end
endmodule
